// ==== verilog/expansion_bus_pin_select.sv ====
// pin function selection for the expansion bus port group and analog pair
// assumes: gpio data/direction and bus signals come from core logic on
// i_clk_sys; pads, strap levels and the secondary reset pin are asynchronous
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "pin_select_defines.svh"

// Overview of operation
// - low address, data, strobes on H, I, J
// - sample six low H straps at power-up
// - development mode drives J2-7 observability signals, large package
// - upper address on K, L0-3, large package
// - diode select swaps converter pins for diode
// - gate A20 stays plain port logic
// - secondary reset acts whatever pin function
// - only protection word enables secondary reset
// - reset clears configuration, pins become ports, H0-5 released until straps taken
module expansion_bus_pin_select (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // register port
  input wire logic [`REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // package option, static bond level
  input wire logic i_large_package,
  // bus interface unit side
  input wire logic [19:0] i_bus_addr,
  input wire logic [15:0] i_bus_wdata,
  input wire logic i_bus_data_oe,
  input wire logic i_bus_rd,
  input wire logic i_bus_wr_low,
  input wire logic i_bus_wr_high,
  input wire logic i_bus_be_mode,
  input wire logic i_addr13_byte_enable_low,
  input wire logic i_addr14_byte_enable_high,
  input wire logic i_addr15_burst_read,
  output logic [15:0] o_bus_rdata,
  // development observability sources
  input wire logic [2:0] i_bus_status,
  input wire logic i_pipe_status,
  input wire logic i_pipeline_indicator,
  input wire logic i_break_reset_out,
  // general-purpose port logic
  input wire logic [`PAD_COUNT-1:0] i_gpio_out,
  input wire logic [`PAD_COUNT-1:0] i_gpio_oe,
  output logic [`PAD_COUNT-1:0] o_gpio_in,
  // pads
  input wire logic [`PAD_COUNT-1:0] i_pad_in,
  output logic [`PAD_COUNT-1:0] o_pad_out,
  output logic [`PAD_COUNT-1:0] o_pad_oe,
  // gate a20 port pin
  input wire logic i_gate_a_twenty_data,
  input wire logic i_gate_a_twenty_dir,
  output logic o_gate_a_twenty_out,
  output logic o_gate_a_twenty_oe,
  // secondary reset
  input wire logic i_secondary_reset_input_n,
  input wire logic i_prot_word_sec_reset_en,
  output logic o_secondary_reset,
  // captured straps and environment
  output logic [`STRAP_W-1:0] o_straps,
  output logic o_development_environment,
  // analog pin pair switches
  output logic o_adc_ch8_sel,
  output logic o_adc_ch9_sel,
  output logic o_diode_negative_sel,
  output logic o_diode_positive_sel
);

  pin_select_pkg::sel_state_t q_ff, nxt_q;

  logic [`PAD_COUNT-1:0] pad_sync;
  logic sec_reset_sync;
  logic strap_done;
  logic development_environment;
  logic expansion_io_enable;
  logic expansion_memory_enable;
  logic wide_expansion_memory;
  logic sel_low;
  logic sel_obs;
  logic sel_high_addr;
  logic sel_wide;
  logic strap_phase;
  logic [`PAD_COUNT-1:0] alt_sel;
  logic [`PAD_COUNT-1:0] alt_out;
  logic [`PAD_COUNT-1:0] alt_oe;

  // pad levels cross in before anything reads them
  pin_sync #(.W(`PAD_COUNT)) u_pad_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(i_pad_in),
    .o_sync(pad_sync)
  );

  pin_sync #(.W(1)) u_sec_reset_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(i_secondary_reset_input_n),
    .o_sync(sec_reset_sync)
  );

  // environment and enables; development mode only once straps are known
  assign strap_done = (q_ff.st == pin_select_pkg::ST_RUN);
  assign development_environment = strap_done &&
    (q_ff.straps[`STRAP_ENV_MSB:`STRAP_ENV_LSB] == `DEVMODE_ENV_CODE);
  assign expansion_io_enable = q_ff.modcfg[`MODCFG_IO_EN_BIT];
  assign expansion_memory_enable = q_ff.modcfg[`MODCFG_MEM_EN_BIT];
  assign wide_expansion_memory = q_ff.modcfg[`MODCFG_WIDE_BIT];
  assign strap_phase = !strap_done;

  assign sel_low = development_environment || expansion_io_enable || expansion_memory_enable;
  assign sel_obs = development_environment && i_large_package;
  assign sel_high_addr = (development_environment || expansion_memory_enable) && i_large_package;
  assign sel_wide = (development_environment ||
    (expansion_memory_enable && wide_expansion_memory)) && i_large_package;

  // per-pin alternate select, sharing pins between groups by position
  always_comb begin
    alt_sel = '0;
    alt_sel[`PAD_J-1:`PAD_H] = {16{sel_low}};
    alt_sel[`PAD_J+1:`PAD_J] = {2{sel_low}};
    alt_sel[`PAD_K-1:`PAD_J+2] = {6{sel_obs}};
    alt_sel[`PAD_L_WR_HIGH-1:`PAD_K] = {12{sel_high_addr}};
    alt_sel[`PAD_COUNT-1:`PAD_L_WR_HIGH] = {9{sel_wide}};
    alt_sel[`STRAP_W-1:0] = alt_sel[`STRAP_W-1:0] | {`STRAP_W{strap_phase}};
  end

  // alternate drive values; strobes are active low on the pins
  always_comb begin
    alt_out = '0;
    alt_oe = '0;
    // address, data, read, low write and observability
    alt_out[`PAD_I-1:`PAD_H] = i_bus_addr[7:0];
    alt_oe[`PAD_I-1:`PAD_H] = {8{strap_done}};
    alt_out[`PAD_J-1:`PAD_I] = i_bus_wdata[7:0];
    alt_oe[`PAD_J-1:`PAD_I] = {8{i_bus_data_oe}};
    alt_out[`PAD_J] = !i_bus_rd;
    alt_out[`PAD_J+1] = !i_bus_wr_low;
    alt_oe[`PAD_J+1:`PAD_J] = 2'h3;
    alt_out[`PAD_K-1:`PAD_J+2] = {i_break_reset_out, i_pipeline_indicator,
      i_pipe_status, i_bus_status};
    alt_oe[`PAD_K-1:`PAD_J+2] = 6'h3f;
    // upper address with byte enable reuse
    alt_out[`PAD_K+4:`PAD_K] = i_bus_addr[12:8];
    alt_out[`PAD_K+5] = i_bus_be_mode ? i_addr13_byte_enable_low : i_bus_addr[13];
    alt_out[`PAD_K+6] = i_bus_be_mode ? i_addr14_byte_enable_high : i_bus_addr[14];
    alt_out[`PAD_K+7] = i_bus_be_mode ? i_addr15_burst_read : i_bus_addr[15];
    alt_out[`PAD_L_WR_HIGH-1:`PAD_L] = i_bus_addr[19:16];
    alt_oe[`PAD_L_WR_HIGH-1:`PAD_K] = 12'hfff;
    // high write strobe and upper data
    alt_out[`PAD_L_WR_HIGH] = !i_bus_wr_high;
    alt_oe[`PAD_L_WR_HIGH] = 1'h1;
    alt_out[`PAD_COUNT-1:`PAD_M] = i_bus_wdata[15:8];
    alt_oe[`PAD_COUNT-1:`PAD_M] = {8{i_bus_data_oe}};
  end

  port_pad_mux #(.W(`PAD_COUNT)) u_pad_mux (
    .i_alt_sel(alt_sel),
    .i_alt_out(alt_out),
    .i_alt_oe(alt_oe),
    .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe),
    .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe)
  );

  // the port always sees its pins, alternate or not
  assign o_gpio_in = pad_sync;
  // read data lands from the synchronised pads, two cycles behind the pins
  assign o_bus_rdata = {pad_sync[`PAD_COUNT-1:`PAD_M], pad_sync[`PAD_J-1:`PAD_I]};

  // gate a20 is just port data and direction
  assign o_gate_a_twenty_out = i_gate_a_twenty_data;
  assign o_gate_a_twenty_oe = i_gate_a_twenty_dir;

  // strap sequence, register file and secondary reset
  always_comb begin
    nxt_q = q_ff;
    nxt_q.rdata = 8'h00;
    case (q_ff.st)
      pin_select_pkg::ST_SETTLE: begin
        // wait until the synchroniser holds post-reset pad levels
        if (q_ff.settle_cnt == `STRAP_SETTLE_CYC) begin
          nxt_q.st = pin_select_pkg::ST_CAPTURE;
        end else begin
          nxt_q.settle_cnt = q_ff.settle_cnt + 2'h1;
        end
      end
      pin_select_pkg::ST_CAPTURE: begin
        nxt_q.straps = pad_sync[`STRAP_W-1:0];
        nxt_q.st = pin_select_pkg::ST_RUN;
      end
      pin_select_pkg::ST_RUN: begin
        nxt_q.st = pin_select_pkg::ST_RUN;
      end
      default: begin
        nxt_q.st = pin_select_pkg::ST_RUN;
      end
    endcase
    // reserved bits are dropped on write and read back as zero
    if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_MODULE_CONFIG: nxt_q.modcfg = i_reg_wdata[`MODCFG_W-1:0];
        `REG_CONVERTER_CONFIG: nxt_q.diode_sel = i_reg_wdata[`DIODE_SEL_BIT];
        default: nxt_q.modcfg = q_ff.modcfg;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_MODULE_CONFIG: nxt_q.rdata[`MODCFG_W-1:0] = q_ff.modcfg;
        `REG_CONVERTER_CONFIG: nxt_q.rdata[`DIODE_SEL_BIT] = q_ff.diode_sel;
        `REG_STRAP_STATUS: begin
          nxt_q.rdata[`STRAP_W-1:0] = q_ff.straps;
          nxt_q.rdata[`STATUS_DEVMODE_BIT] = development_environment;
          nxt_q.rdata[`STATUS_DONE_BIT] = strap_done;
        end
        default: nxt_q.rdata = 8'h00;
      endcase
    end
    // protection word only; synchroniser clears low, so wait it out
    nxt_q.sec_reset = i_prot_word_sec_reset_en && !sec_reset_sync && strap_done;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      q_ff.st <= pin_select_pkg::ST_SETTLE;
      q_ff.settle_cnt <= 2'h0;
      q_ff.modcfg <= `MODCFG_RST;
      q_ff.diode_sel <= 1'h0;
      q_ff.straps <= `STRAP_RST;
      q_ff.rdata <= 8'h00;
      q_ff.sec_reset <= 1'h0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from state
  assign o_reg_rdata = q_ff.rdata;
  assign o_secondary_reset = q_ff.sec_reset;
  assign o_straps = q_ff.straps;
  assign o_development_environment = development_environment;
  // analog pair switches, break before make is left to the pad cell
  assign o_adc_ch8_sel = !q_ff.diode_sel;
  assign o_adc_ch9_sel = !q_ff.diode_sel;
  assign o_diode_negative_sel = q_ff.diode_sel;
  assign o_diode_positive_sel = q_ff.diode_sel;

  // checks on pin ownership and register effects
  property p_low_bus;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (strap_done && sel_low) |-> (o_pad_out[`PAD_J] == !i_bus_rd) && o_pad_oe[`PAD_J + 1]
      && (o_pad_out[`PAD_H] == i_bus_addr[0]);
  endproperty
  a_low_bus: assert property (p_low_bus) else $error("low bus pins not routed");

  property p_strap;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (q_ff.st == pin_select_pkg::ST_CAPTURE) |=> (o_straps == $past(pad_sync[`STRAP_W-1:0]))
      ##1 (o_straps == $past(o_straps));
  endproperty
  a_strap: assert property (p_strap) else $error("strap capture wrong");

  property p_obs;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !development_environment |-> (o_pad_oe[`PAD_K-1:`PAD_J+2] == i_gpio_oe[`PAD_K-1:`PAD_J+2]);
  endproperty
  a_obs: assert property (p_obs) else $error("observability pins not left to port");

  property p_high_addr;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (expansion_memory_enable && i_large_package && !i_bus_be_mode) |->
      (o_pad_out[`PAD_K+7:`PAD_K] == i_bus_addr[15:8]) && o_pad_oe[`PAD_L];
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("upper address not routed");

  property p_wide;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (!development_environment && !wide_expansion_memory) |->
      (o_pad_out[`PAD_COUNT-1:`PAD_L_WR_HIGH] == i_gpio_out[`PAD_COUNT-1:`PAD_L_WR_HIGH]);
  endproperty
  a_wide: assert property (p_wide) else $error("wide pins taken while narrow");

  property p_diode;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (i_reg_wr && (i_reg_addr == `REG_CONVERTER_CONFIG)) |=>
      (o_diode_positive_sel == $past(i_reg_wdata[`DIODE_SEL_BIT]))
      && (o_adc_ch8_sel != o_diode_negative_sel);
  endproperty
  a_diode: assert property (p_diode) else $error("diode select not applied");

  property p_sec_rst;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !i_prot_word_sec_reset_en |=> !o_secondary_reset;
  endproperty
  a_sec_rst: assert property (p_sec_rst) else $error("secondary reset without enable");

  property p_cleared;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (q_ff.st == pin_select_pkg::ST_SETTLE && q_ff.settle_cnt == 2'h0) |->
      (q_ff.modcfg == `MODCFG_RST) && !q_ff.diode_sel && !development_environment;
  endproperty
  a_cleared: assert property (p_cleared) else $error("configuration not cleared");

  property p_gpio;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (strap_done && !sel_low && !sel_high_addr && !sel_wide && !sel_obs) |->
      (o_pad_out == i_gpio_out) && (o_pad_oe == i_gpio_oe);
  endproperty
  a_gpio: assert property (p_gpio) else $error("port lost its pin");

endmodule

`default_nettype wire

// ==== inc/pin_select_defines.svh ====
// constants for the expansion bus pin selection block
// assumes: included by bare name from package and design files
`ifndef PIN_SELECT_DEFINES_SVH
`define PIN_SELECT_DEFINES_SVH

// register indexes on the plain register port
`define REG_ADDR_W 4
`define REG_MODULE_CONFIG 4'h0
`define REG_CONVERTER_CONFIG 4'h1
`define REG_STRAP_STATUS 4'h2

// module_config_reg, converter and status register fields
`define MODCFG_W 5
`define MODCFG_RST 5'h00
`define MODCFG_IO_EN_BIT 0
`define MODCFG_MEM_EN_BIT 1
`define MODCFG_WIDE_BIT 2
`define DIODE_SEL_BIT 0
`define STATUS_DEVMODE_BIT 6
`define STATUS_DONE_BIT 7

// strap layout on the low port H pins
`define STRAP_W 6
`define STRAP_RST 6'h00
`define STRAP_ENV_LSB 0
`define STRAP_ENV_MSB 1
`define DEVMODE_ENV_CODE 2'h3
`define STRAP_SETTLE_CYC 2'h2

// pad vector layout: H, I, J, K, L0-4, M
`define PAD_COUNT 45
`define PAD_H 0
`define PAD_I 8
`define PAD_J 16
`define PAD_K 24
`define PAD_L 32
`define PAD_L_WR_HIGH 36
`define PAD_M 37

`endif

// ==== inc/pin_select_pkg.sv ====
// types for the expansion bus pin selection block
// assumes: pin_select_defines.svh sits on the include path
`default_nettype none
`include "pin_select_defines.svh"

package pin_select_pkg;

  // strap capture sequence after reset release
  typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_RUN} strap_state_t;

  // whole state of the selection block
  typedef struct packed {
    strap_state_t st;
    logic [1:0] settle_cnt;
    logic [`MODCFG_W-1:0] modcfg;
    logic diode_sel;
    logic [`STRAP_W-1:0] straps;
    logic [7:0] rdata;
    logic sec_reset;
  } sel_state_t;

endpackage

`default_nettype wire

// ==== verilog/pin_sync.sv ====
// two flip-flop synchroniser for pad levels
// assumes: inputs are asynchronous levels, no pulses shorter than a clock
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q_ff, nxt_q;

  // meta stage feeds only the stable stage
  always_comb begin
    nxt_q = q_ff;
    nxt_q.meta = i_async;
    nxt_q.stable = q_ff.meta;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_sync = q_ff.stable;

endmodule

`default_nettype wire

// ==== verilog/port_pad_mux.sv ====
// per-pin choice between alternate function and general-purpose port
// assumes: select, data and enables all come from the system clock domain
`timescale 1ns/10ps
`default_nettype none

module port_pad_mux #(
  parameter int W = 8
) (
  // selection
  input wire logic [W-1:0] i_alt_sel,
  // alternate function drive
  input wire logic [W-1:0] i_alt_out,
  input wire logic [W-1:0] i_alt_oe,
  // general-purpose port drive
  input wire logic [W-1:0] i_gpio_out,
  input wire logic [W-1:0] i_gpio_oe,
  // pad drive
  output logic [W-1:0] o_pad_out,
  output logic [W-1:0] o_pad_oe
);

  // one mux per pin; the port keeps the pin whenever no alternate is chosen
  for (genvar g = 0; g < W; g++) begin : g_pin
    assign o_pad_out[g] = i_alt_sel[g] ? i_alt_out[g] : i_gpio_out[g];
    assign o_pad_oe[g] = i_alt_sel[g] ? i_alt_oe[g] : i_gpio_oe[g];
  end

endmodule

`default_nettype wire

// ==== test/exp_mem_model.sv ====
// far-side model: expansion memory data bus and strap resistors on pads
// assumes: pad layout of the defines header; the bench resolves each wire
`timescale 1ns/10ps
`default_nettype none
`include "pin_select_defines.svh"

module exp_mem_model (
  // clock
  input wire logic i_clk_sys,
  // device pad drive
  input wire logic [`PAD_COUNT-1:0] i_pad_out,
  input wire logic [`PAD_COUNT-1:0] i_pad_oe,
  // strap levels and memory word
  input wire logic [`STRAP_W-1:0] i_strap,
  input wire logic [15:0] i_word,
  // far-side drive, used only where the device does not drive
  output logic [`PAD_COUNT-1:0] o_drive
);
  logic tgl_ff = 1'h0;
  logic rd_act;

  // released lines flip every cycle so a stale level never passes as data
  always_ff @(posedge i_clk_sys) begin
    tgl_ff <= ~tgl_ff;
  end

  // read strobe pin is active low
  assign rd_act = i_pad_oe[`PAD_J] & ~i_pad_out[`PAD_J];

  // strap resistors always present, memory answers only while read is low
  always_comb begin
    o_drive = {`PAD_COUNT{tgl_ff}};
    o_drive[`PAD_H +: `STRAP_W] = i_strap;
    if (rd_act) begin
      o_drive[`PAD_I +: 8] = i_word[7:0];
      o_drive[`PAD_M +: 8] = i_word[15:8];
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// bench for the expansion bus pin selection block, scoreboard queue
// assumes: design files and the partner model compiled before this file
`timescale 1ns/10ps
`default_nettype none
`include "pin_select_defines.svh"
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("BAD %0t kind %0d got %h", $time, n.k, a); \
  end \
end

module testbench;
  typedef struct {int k; logic [89:0] v;} note_t;
  note_t q[$];
  note_t n;
  int mismatches = 0;
  int comparisons = 0;
  logic clk = 1'h0, rstn = 1'h0, rwr = 1'h0, rrd = 1'h0, lg = 1'h0;
  logic [31:0] seed = 32'h1366;
  logic [3:0] ra = 4'h0;
  logic [7:0] rwd = 8'h00, rdata;
  logic [19:0] ba = 20'h0;
  logic [15:0] bwd = 16'h0, word = 16'h0, brdata;
  logic doe = 1'h0, brd = 1'h0, wlo = 1'h0, whi = 1'h0, bem = 1'h0;
  logic be0 = 1'h0, be1 = 1'h0, cbrd = 1'h0, pst = 1'h0, pind = 1'h0, brk = 1'h0;
  logic [2:0] bst = 3'h0;
  logic gad = 1'h0, gadir = 1'h0, r2n = 1'h1, r2en = 1'h0;
  logic [44:0] gout = 45'h0, goe = 45'h0, pout, poe, pin, drv, gin;
  logic [5:0] strap = 6'h0, stro;
  logic sres, a8, a9, dneg, dpos, gao, gaoe, devo;

  // clock
  always #5 clk = ~clk;

  // wire level: device drive wins where enabled
  assign pin = (poe & pout) | (~poe & drv);

  expansion_bus_pin_select expansion_bus_pin_select_i (
    .i_clk_sys(clk), .i_resetn(rstn), .i_reg_addr(ra), .i_reg_wdata(rwd),
    .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdata), .i_large_package(lg),
    .i_bus_addr(ba), .i_bus_wdata(bwd), .i_bus_data_oe(doe), .i_bus_rd(brd),
    .i_bus_wr_low(wlo), .i_bus_wr_high(whi), .i_bus_be_mode(bem),
    .i_addr13_byte_enable_low(be0), .i_addr14_byte_enable_high(be1),
    .i_addr15_burst_read(cbrd), .o_bus_rdata(brdata), .i_bus_status(bst),
    .i_pipe_status(pst), .i_pipeline_indicator(pind), .i_break_reset_out(brk),
    .i_gpio_out(gout), .i_gpio_oe(goe), .o_gpio_in(gin), .i_pad_in(pin),
    .o_pad_out(pout), .o_pad_oe(poe), .i_gate_a_twenty_data(gad),
    .i_gate_a_twenty_dir(gadir), .o_gate_a_twenty_out(gao), .o_gate_a_twenty_oe(gaoe),
    .i_secondary_reset_input_n(r2n), .i_prot_word_sec_reset_en(r2en),
    .o_secondary_reset(sres), .o_straps(stro), .o_development_environment(devo),
    .o_adc_ch8_sel(a8), .o_adc_ch9_sel(a9), .o_diode_negative_sel(dneg),
    .o_diode_positive_sel(dpos)
  );

  exp_mem_model exp_mem_model_i (
    .i_clk_sys(clk), .i_pad_out(pout), .i_pad_oe(poe), .i_strap(strap),
    .i_word(word), .o_drive(drv)
  );

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // expected pad drive from config, environment and package
  function automatic logic [89:0] exp_pads(logic [2:0] m, logic d, logic l);
    logic [44:0] s, ao, ae;
    ao = {bwd[15:8], ~whi, ba[19:16], bem ? {cbrd, be1, be0} : ba[15:13], ba[12:8],
          brk, pind, pst, bst, ~wlo, ~brd, bwd[7:0], ba[7:0]};
    // M follows data enable, L4 down to J0 always driven, I data enable, H driven
    ae = {{8{doe}}, 13'h1fff, 8'hff, {8{doe}}, 8'hff};
    s = {{9{(d | (m[1] & m[2])) & l}}, {12{(d | m[1]) & l}}, {6{d & l}}, {18{d | m[0] | m[1]}}};
    return {(s & ao) | (~s & gout), (s & ae) | (~s & goe)};
  endfunction

  function automatic logic [6:0] misc(logic sr, logic r);
    return {sr, ~r, ~r, r, r, gad, gadir};
  endfunction

  task automatic note(int k, logic [89:0] v);
    #1;
    q.push_back('{k, v});
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'h1;
    @(posedge clk);
    rwr <= 1'h0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    ra <= a;
    rrd <= 1'h1;
    @(posedge clk);
    rrd <= 1'h0;
    note(2, 90'(e));
  endtask

  task automatic rnd_in(logic l);
    @(posedge clk);
    lg <= l;
    ba <= 20'(rnd());
    bwd <= 16'(rnd());
    {doe, brd, wlo, whi, bem, be0, be1, cbrd} <= 8'(rnd());
    {bst, pst, pind, brk, gad, gadir} <= 8'(rnd());
    gout <= {13'(rnd()), rnd()};
    goe <= {13'(rnd()), rnd()};
    // let the new inputs land before any expectation reads them
    #1;
  endtask

  // firmware pairs this pin with an interrupt; none modelled here
  task automatic r2set(logic en, logic pn);
    @(posedge clk);
    r2en <= en;
    r2n <= pn;
    repeat (4) @(posedge clk);
  endtask

  task automatic do_reset(logic [5:0] s);
    @(posedge clk);
    strap <= s;
    rstn <= 1'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (6) @(posedge clk);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // scoreboard: all pending notes compared in the low clock phase
  always @(negedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.k)
        1: `CHK({pout, poe}, n.v)
        2: `CHK(90'(rdata), n.v)
        3: `CHK(90'({sres, a8, a9, dneg, dpos, gao, gaoe}), n.v)
        5: `CHK(90'({devo, stro}), n.v)
        default: `CHK(90'({gin[44:37], gin[15:8], brdata}), n.v)
      endcase
    end
  end

  // main sequence
  initial begin
    logic [31:0] w;
    logic [7:0] d;
    do_reset(6'h2d);
    rd(4'h2, 8'had);
    note(5, 90'({1'h0, 6'h2d}));
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    note(3, 90'(misc(1'h0, 1'h0)));
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      w = rnd();
      d = {w[7:3], i[2:0]};
      wr(4'h0, d);
      rnd_in(i[3]);
      note(1, exp_pads(d[2:0], 1'h0, i[3]));
      rd(4'h0, {3'h0, d[4:0]});
    end
    $display("test selection done");
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h07);
    r2set(1'h0, 1'h0);
    note(3, 90'(misc(1'h0, 1'h0)));
    r2set(1'h1, 1'h0);
    note(3, 90'(misc(1'h1, 1'h0)));
    r2set(1'h1, 1'h1);
    note(3, 90'(misc(1'h0, 1'h0)));
    $display("test secondary reset done");
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h01);
    note(3, 90'(misc(1'h0, 1'h1)));
    wr(4'h1, 8'h00);
    rnd_in(1'h1);
    note(3, 90'(misc(1'h0, 1'h0)));
    $display("test analog pair done");
    @(posedge clk);
    brd <= 1'h1;
    doe <= 1'h0;
    word <= 16'(rnd());
    repeat (5) @(posedge clk);
    note(1, exp_pads(3'h7, 1'h0, 1'h1));
    note(4, 90'({word, word}));
    $display("test bus read done");
    w = rnd();
    do_reset({w[3:0], 2'h3});
    rd(4'h2, {2'h3, w[3:0], 2'h3});
    note(5, 90'({1'h1, w[3:0], 2'h3}));
    rd(4'h0, 8'h00);
    for (int l = 0; l < 2; l++) begin
      rnd_in(l[0]);
      note(1, exp_pads(3'h0, 1'h1, l[0]));
    end
    $display("test development done");
    repeat (2) @(posedge clk);
    final_report();
  end

  // watchdog
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
